// ==== common/plfc_cfg.svh ====
// Offsets, field positions, reset values and timing counts
// Summary of operation
// R1 - Rule bit 0: forward non-protocol frames untouched
// R2 - Rule bit 0: sender address left unchanged
// R3 - Rule bit 1: destroy non-protocol frames; resets 1
// R4 - Rule bit 1: force sender address bit 1
// R5 - Temporary bit: loop settings revert after one second
// R6 - Port 0 loop field bits 9:8, four modes
// R7 - Open loop passes; closed loop skips the port
// R8 - Auto mode: close at link down, open up
// R9 - Auto-close reopens on rewrite or valid frame
// R10 - Forced modes ignore the link state
// R11 - Port 1 loop field bits 11:10, same modes
// R12 - Loop changes wait for the port's frame end
// R13 - Only fieldbus side writes; host writes ignored
// R14 - Reserved bits 7:2 read zero
`ifndef PLFC_CFG_SVH
`define PLFC_CFG_SVH
`define PLFC_LLC_OFFSET 16'h0100
`define PLFC_FWD_BIT 0
`define PLFC_TMP_BIT 1
`define PLFC_LOOP0_LSB 8
`define PLFC_LOOP1_LSB 10
`define PLFC_FWD_RESET 1'b1
`define PLFC_TMP_RESET 1'b0
`define PLFC_LOOP_RESET 2'h0
`define PLFC_TEMP_TIME_MS 1000
`define PLFC_CLK_MHZ 250
`define PLFC_TEMP_CYCLES (`PLFC_TEMP_TIME_MS * 1000 * `PLFC_CLK_MHZ)
`endif

// ==== common/plfc_pkg.sv ====
// Types for the port loop and forwarding control
package plfc_pkg;
    typedef enum logic [1:0] {
        PLFC_LOOP_AUTO = 2'h0,
        PLFC_LOOP_AUTO_CLOSE = 2'h1,
        PLFC_LOOP_OPEN = 2'h2,
        PLFC_LOOP_CLOSED = 2'h3
    } plfc_loop_mode_t;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
        logic sof;
        logic eof;
        logic is_protocol;
    } plfc_byte_t;
endpackage

// ==== src/plfc_loop_port.sv ====
// One port's loop state machine
`timescale 1ns/1ns
module plfc_loop_port
    import plfc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    input wire logic rewrite_i,
    input wire logic link_up_i,
    input wire logic valid_frame_i,
    input wire logic busy_i,
    output logic open_o
);
    typedef enum {PLFC_ST_CLOSED, PLFC_ST_OPEN} plfc_port_state_t;
    plfc_port_state_t state;
    plfc_port_state_t next_state;
    logic reopen;
    logic next_reopen;
    logic want_open;

    always_comb begin
        want_open = (state == PLFC_ST_OPEN);
        next_reopen = 1'b0;
        case (plfc_loop_mode_t'(mode_i))
            PLFC_LOOP_AUTO: want_open = link_up_i; // R8
            PLFC_LOOP_AUTO_CLOSE: begin
                if (!link_up_i) begin
                    want_open = 1'b0; // R9
                end else if (rewrite_i || valid_frame_i || reopen) begin
                    want_open = 1'b1; // R9
                    // Reopen request waits out a busy port
                    next_reopen = busy_i; // R12
                end
            end
            PLFC_LOOP_OPEN: want_open = 1'b1; // R10
            PLFC_LOOP_CLOSED: want_open = 1'b0; // R10
            default: want_open = 1'b0;
        endcase
        next_state = state;
        if (!busy_i) begin
            next_state = want_open ? PLFC_ST_OPEN : PLFC_ST_CLOSED; // R12
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= PLFC_ST_CLOSED;
            reopen <= 1'b0;
        end else begin
            state <= next_state;
            reopen <= next_reopen;
        end
    end

    assign open_o = (state == PLFC_ST_OPEN);
endmodule

// ==== src/plfc_top.sv ====
// Link layer control low half: forwarding and port loops
`timescale 1ns/1ns
`include "plfc_cfg.svh"
module plfc_top
    import plfc_pkg::*;
#(
    parameter int TEMP_CYCLES = `PLFC_TEMP_CYCLES
)
(
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic FB_WR_I,
    input wire logic [15:0] FB_ADDR_I,
    input wire logic [3:0] FB_BE_I,
    input wire logic [31:0] FB_WDATA_I,
    input wire logic HDI_WR_I,
    input wire logic [15:0] RD_ADDR_I,
    output logic [31:0] RD_DATA_O,
    input wire logic [1:0] LINK_UP_I,
    input wire logic [1:0] RX_VALID_FRAME_I,
    input wire logic [1:0] PORT_BUSY_I,
    input wire plfc_byte_t RX_I,
    output plfc_byte_t TX_O,
    output logic [1:0] PORT_OPEN_O
);
    logic fwd;
    logic next_fwd;
    logic tmp;
    logic next_tmp;
    logic [3:0] loops;
    logic [3:0] next_loops;
    logic [3:0] saved;
    logic [3:0] next_saved;
    logic [31:0] tcnt;
    logic [31:0] next_tcnt;
    logic [1:0] rewrite;
    logic [1:0] next_rewrite;
    logic [1:0] open;
    plfc_byte_t tx;
    plfc_byte_t next_tx;
    logic [31:0] rd;
    logic [31:0] next_rd;
    logic [7:0] bpos;
    logic [7:0] next_bpos;
    logic drop;
    logic next_drop;
    logic wr_lo;
    logic wr_hi;

    // Register hit for one byte lane
    function automatic logic lane_hit(
        input logic wr,
        input logic [15:0] addr,
        input logic en
    );
        return wr && addr == `PLFC_LLC_OFFSET && en;
    endfunction

    // Loop field asks for auto-close
    function automatic logic is_auto_close(input logic [1:0] field);
        return field == 2'(PLFC_LOOP_AUTO_CLOSE);
    endfunction

    // Host writes are not decoded at all
    assign wr_lo = lane_hit(FB_WR_I, FB_ADDR_I, FB_BE_I[0]); // R13
    assign wr_hi = lane_hit(FB_WR_I, FB_ADDR_I, FB_BE_I[1]); // R13

    always_comb begin
        next_fwd = fwd;
        next_tmp = tmp;
        next_loops = loops;
        next_saved = saved;
        next_tcnt = tcnt;
        next_rewrite = 2'h0;
        if (wr_lo) begin
            next_fwd = FB_WDATA_I[`PLFC_FWD_BIT];
            next_tmp = FB_WDATA_I[`PLFC_TMP_BIT];
        end
        if (wr_hi) begin
            next_loops = FB_WDATA_I[`PLFC_LOOP0_LSB +: 4];
            next_rewrite[0] = is_auto_close(
                FB_WDATA_I[`PLFC_LOOP0_LSB +: 2]); // R9
            next_rewrite[1] = is_auto_close(
                FB_WDATA_I[`PLFC_LOOP1_LSB +: 2]); // R11
            if (wr_lo ? FB_WDATA_I[`PLFC_TMP_BIT] : tmp) begin
                if (tcnt == 32'h0) begin
                    next_saved = loops; // R5
                end
                next_tcnt = 32'(TEMP_CYCLES); // R5
            end else begin
                next_tcnt = 32'h0;
            end
        end else if (tcnt == 32'h1) begin
            next_loops = saved; // R5
            next_tcnt = 32'h0;
        end else if (tcnt != 32'h0) begin
            next_tcnt = tcnt - 32'h1;
        end
    end

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            fwd <= `PLFC_FWD_RESET; // R3
            tmp <= `PLFC_TMP_RESET;
            loops <= {`PLFC_LOOP_RESET, `PLFC_LOOP_RESET}; // R6 R11
            saved <= 4'h0;
            tcnt <= 32'h0;
            rewrite <= 2'h0;
        end else begin
            fwd <= next_fwd;
            tmp <= next_tmp;
            loops <= next_loops;
            saved <= next_saved;
            tcnt <= next_tcnt;
            rewrite <= next_rewrite;
        end
    end

    plfc_loop_port u_port0 (
        .clk_i(MCLK_I),
        .rst_i(RESET_I),
        .mode_i(loops[1:0]), // R6
        .rewrite_i(rewrite[0]),
        .link_up_i(LINK_UP_I[0]),
        .valid_frame_i(RX_VALID_FRAME_I[0]),
        .busy_i(PORT_BUSY_I[0]),
        .open_o(open[0])
    );

    plfc_loop_port u_port1 (
        .clk_i(MCLK_I),
        .rst_i(RESET_I),
        .mode_i(loops[3:2]), // R11
        .rewrite_i(rewrite[1]),
        .link_up_i(LINK_UP_I[1]),
        .valid_frame_i(RX_VALID_FRAME_I[1]),
        .busy_i(PORT_BUSY_I[1]),
        .open_o(open[1])
    );

    // Frame path: byte 6 of a frame holds bit 1 of the sender address
    always_comb begin
        next_tx = RX_I;
        next_bpos = bpos;
        next_drop = drop;
        if (RX_I.valid) begin
            next_bpos = RX_I.sof ? 8'h1 : (bpos == 8'hff ? bpos : bpos + 8'h1);
            if (RX_I.sof) begin
                next_drop = fwd && !RX_I.is_protocol; // R3
            end
            if (fwd && RX_I.is_protocol && (RX_I.sof ? 8'h0 : bpos) == 8'h6)
            begin
                next_tx.data = RX_I.data | 8'h02; // R4
            end
            // Without the rule bit every byte passes untouched, except the rest of a frame whose start was dropped
            if (RX_I.sof ? (fwd && !RX_I.is_protocol) : drop) begin
                next_tx.valid = 1'b0; // R3
            end
        end
        next_rd = 32'h0;
        if (RD_ADDR_I == `PLFC_LLC_OFFSET) begin
            next_rd[`PLFC_FWD_BIT] = fwd;
            next_rd[`PLFC_TMP_BIT] = tmp;
            next_rd[`PLFC_LOOP0_LSB +: 4] = loops; // R14
        end
    end

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            tx <= '0;
            bpos <= 8'h0;
            drop <= 1'b0;
            rd <= 32'h0;
            PORT_OPEN_O <= 2'h0;
        end else begin
            tx <= next_tx; // R1 R2
            bpos <= next_bpos;
            drop <= next_drop;
            rd <= next_rd;
            PORT_OPEN_O <= open; // R7
        end
    end

    assign TX_O = tx;
    assign RD_DATA_O = rd;
endmodule

// ==== sim/plfc_top_sva.sv ====
// Checker for the loop and forwarding control ports
`timescale 1ns/1ns
module plfc_top_sva
    import plfc_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic [15:0] RD_ADDR_I,
    input wire logic [31:0] RD_DATA_O,
    input wire logic [1:0] LINK_UP_I,
    input wire logic [1:0] PORT_BUSY_I,
    input wire plfc_byte_t RX_I,
    input wire plfc_byte_t TX_O,
    input wire logic [1:0] PORT_OPEN_O
);
    logic on;
    logic mark;
    logic [3:0] pos;
    wire [3:0] ps = RX_I.sof ? 4'h0 : pos;
    wire fwd = on & RD_DATA_O[0];
    wire [4:0] m = {on, RD_DATA_O[11:8]};
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            on <= 1'b0;
            mark <= 1'b0;
            pos <= 4'h0;
        end else begin
            on <= RD_ADDR_I == 16'h0100;
            mark <= RX_I.valid & RX_I.is_protocol & ps == 4'h6;
            if (RX_I.valid && ps != 4'hf) begin
                pos <= ps + 4'h1;
            end
        end
    end
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);
    reserved_zero_a: assert property (
        on |-> RD_DATA_O[7:2] == 6'h0 && RD_DATA_O[31:12] == 20'h0)
        else $error("reserved bits set");
    copy_through_a: assert property (
        on && !RD_DATA_O[0] && $past(RX_I.valid) |-> TX_O == $past(RX_I))
        else $error("frame altered");
    drop_foreign_a: assert property (
        fwd && $past(RX_I.valid && !RX_I.is_protocol) |-> !TX_O.valid)
        else $error("foreign byte passed");
    addr_mark_a: assert property (
        fwd && mark |-> TX_O.data == ($past(RX_I.data) | 8'h02))
        else $error("sender address not marked");
    forced_port0_a: assert property (
        (m[4] && m[1] && !PORT_BUSY_I[0] && $stable(m)) [*4]
        |-> PORT_OPEN_O[0] == !m[0])
        else $error("port 0 forced mode");
    forced_port1_a: assert property (
        (m[4] && m[3] && !PORT_BUSY_I[1] && $stable(m)) [*4]
        |-> PORT_OPEN_O[1] == !m[2])
        else $error("port 1 forced mode");
    auto_loop_a: assert property (
        (m[4] && m[1:0] == 2'h0 && !PORT_BUSY_I[0]
        && $stable({m, LINK_UP_I[0]})) [*4] |-> PORT_OPEN_O[0] == LINK_UP_I[0])
        else $error("auto loop mismatch");
    busy_hold_a: assert property (
        PORT_BUSY_I[0] [*4] |-> $stable(PORT_OPEN_O[0]))
        else $error("loop moved in frame");
endmodule
bind plfc_top plfc_top_sva u_sva (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
    .RD_ADDR_I(RD_ADDR_I), .RD_DATA_O(RD_DATA_O), .LINK_UP_I(LINK_UP_I),
    .PORT_BUSY_I(PORT_BUSY_I), .RX_I(RX_I), .TX_O(TX_O),
    .PORT_OPEN_O(PORT_OPEN_O));

// ==== sim/plfc_peer.sv ====
// Far side model: link levels and incoming frames
`timescale 1ns/1ns
module plfc_peer
    import plfc_pkg::*;
(
    input wire logic clk_i,
    output plfc_byte_t rx_o,
    output logic [1:0] link_up_o,
    output logic [1:0] valid_frame_o
);
    initial rx_o = '0;
    initial link_up_o = 2'h3;
    initial valid_frame_o = 2'h0;
    task automatic set_link(input logic [1:0] v);
        @(posedge clk_i);
        link_up_o <= v;
    endtask
    task automatic send(input logic proto);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            rx_o <= {8'(i * 16), 1'b1, i == 0, i == 7, proto};
        end
        @(posedge clk_i);
        rx_o <= {~rx_o.data, 4'h0};
        valid_frame_o <= 2'h3;
        @(posedge clk_i);
        valid_frame_o <= 2'h0;
    endtask
endmodule

// ==== sim/plfc_top_tb.sv ====
// Bench for the loop and forwarding control
`timescale 1ns/1ns
module plfc_top_tb;
    import plfc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fb_wr = 1'b0;
    logic hdi_wr = 1'b0;
    logic [15:0] addr = 16'h0100;
    logic [3:0] be = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [1:0] busy = 2'h0;
    logic [31:0] rd;
    logic [1:0] link;
    logic [1:0] vf;
    logic [1:0] po;
    plfc_byte_t rx;
    plfc_byte_t tx;
    int num_errors = 0;
    int tests_run = 0;
    int n_tx = 0;
    int n0;
    logic [15:0] raddr = 16'h0100;
    logic [7:0] b6;
    initial forever #2 clk = ~clk;
    plfc_top #(.TEMP_CYCLES(50)) dut (.MCLK_I(clk), .RESET_I(rst),
        .FB_WR_I(fb_wr), .FB_ADDR_I(addr), .FB_BE_I(be), .FB_WDATA_I(wd),
        .HDI_WR_I(hdi_wr), .RD_ADDR_I(raddr), .RD_DATA_O(rd),
        .LINK_UP_I(link), .RX_VALID_FRAME_I(vf), .PORT_BUSY_I(busy),
        .RX_I(rx), .TX_O(tx), .PORT_OPEN_O(po));
    plfc_peer peer (.clk_i(clk), .rx_o(rx), .link_up_o(link),
        .valid_frame_o(vf));
    always @(posedge clk) begin
        if (tx.valid === 1'b1) begin
            n_tx++;
            if (tx.data[7:4] == 4'h6) begin
                b6 = tx.data;
            end
        end
    end
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(logic w, logic [15:0] a, logic [3:0] b, logic [31:0] d);
        @(posedge clk);
        fb_wr <= w;
        hdi_wr <= !w;
        addr <= a;
        be <= b;
        wd <= d;
        @(posedge clk);
        fb_wr <= 1'b0;
        hdi_wr <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk("rsvd", 32'h0, rd & 32'hfffff0fc);
    endtask
    task automatic op(logic [1:0] e);
        repeat (4) @(posedge clk);
        #1 chk("open", 32'(e), 32'(po));
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk("reg", 32'h1, rd);
        @(posedge clk);
        raddr <= 16'h0104;
        repeat (2) @(posedge clk);
        #1 chk("other", 32'h0, rd);
        @(posedge clk);
        raddr <= 16'h0100;
        wr(1, 16'h0100, 4'hf, 32'hfffffffd);
        chk("reg", 32'hf01, rd);
        op(2'h0);
        wr(0, 16'h0100, 4'hf, 32'h0a00);
        chk("reg", 32'hf01, rd);
        wr(1, 16'h0104, 4'hf, 32'h0a00);
        chk("reg", 32'hf01, rd);
        @(posedge clk);
        busy <= 2'h3;
        wr(1, 16'h0100, 4'h2, 32'h0a00);
        op(2'h0);
        @(posedge clk);
        busy <= 2'h0;
        op(2'h3);
        wr(1, 16'h0100, 4'h2, 32'h0);
        peer.set_link(2'h0);
        op(2'h0);
        peer.set_link(2'h3);
        op(2'h3);
        wr(1, 16'h0100, 4'h2, 32'h0500);
        peer.set_link(2'h0);
        op(2'h0);
        peer.set_link(2'h3);
        op(2'h0);
        wr(1, 16'h0100, 4'h2, 32'h0500);
        op(2'h3);
        peer.set_link(2'h0);
        op(2'h0);
        peer.set_link(2'h3);
        @(posedge clk);
        busy <= 2'h3;
        wr(1, 16'h0100, 4'h2, 32'h0500);
        op(2'h0);
        @(posedge clk);
        busy <= 2'h0;
        op(2'h3);
        peer.set_link(2'h0);
        op(2'h0);
        peer.set_link(2'h3);
        peer.send(1);
        op(2'h3);
        wr(1, 16'h0100, 4'h3, 32'h0a01);
        n0 = n_tx;
        peer.send(1);
        peer.send(0);
        op(2'h3);
        chk("tx", 32'h8, n_tx - n0);
        chk("mark", {24'h0, 8'h62}, {24'h0, b6});
        wr(1, 16'h0100, 4'h1, 32'h0);
        n0 = n_tx;
        peer.send(0);
        op(2'h3);
        chk("tx", 32'h8, n_tx - n0);
        chk("mark", {24'h0, 8'h60}, {24'h0, b6});
        wr(1, 16'h0100, 4'h1, 32'h3);
        wr(1, 16'h0100, 4'h2, 32'h0f00);
        op(2'h0);
        repeat (60) @(posedge clk);
        op(2'h3);
        chk("reg", 32'h0a03, rd);
        give_verdict();
    end
endmodule
